// file: afe_extractor.sv
`timescale 1ns/1ps
`include "afe_params.svh"

module afe_extractor (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [9:0] DIN_DATA,
  input wire logic DIN_SOP,
  input wire logic DIN_EOP,
  input wire logic DIN_VALID,
  output logic DIN_READY,
  output logic [9:0] DOUT_DATA,
  output logic DOUT_SOP,
  output logic DOUT_EOP,
  output logic DOUT_VALID,
  input wire logic DOUT_READY,
  output logic IRQ
);

  // ---------------- stream path ----------------
  afe_pkg::afe_beat_s in_beat;
  afe_pkg::afe_beat_s out_ff;
  afe_pkg::afe_beat_s skid_ff;
  logic out_valid_ff;
  logic skid_valid_ff;
  logic nxt_skid_valid;
  logic ready_ff;
  logic accept;
  logic [3:0] pkt_type;
  logic [3:0] pkt_type_ff;
  logic is_anc;
  logic pass_ff;
  logic pkt_pass;
  logic pkt_pass_ff;
  logic keep;
  logic out_free;

  assign in_beat = '{data: DIN_DATA, sop: DIN_SOP, eop: DIN_EOP};
  assign accept = DIN_VALID && ready_ff;
  assign pkt_type = DIN_SOP ? DIN_DATA[3:0] : pkt_type_ff;
  assign is_anc = (pkt_type == `AFE_TYPE_ANC);
  // pass decision frozen per packet so no packet is cut short
  assign pkt_pass = DIN_SOP ? (pass_ff && !is_anc) : pkt_pass_ff;
  assign keep = accept && pkt_pass;
  assign out_free = !out_valid_ff || DOUT_READY;

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pkt_type_ff <= `AFE_TYPE_VIDEO;
      pkt_pass_ff <= 1'b0;
    end
    else if (accept && DIN_SOP)
    begin
      pkt_type_ff <= DIN_DATA[3:0];
      pkt_pass_ff <= pkt_pass;
    end
  end

  always_comb
  begin
    nxt_skid_valid = skid_valid_ff;
    if (out_free)
      nxt_skid_valid = 1'b0;
    else if (keep)
      nxt_skid_valid = 1'b1;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      out_ff <= '0;
      skid_ff <= '0;
      out_valid_ff <= 1'b0;
      skid_valid_ff <= 1'b0;
      ready_ff <= 1'b0;
    end
    else
    begin
      skid_valid_ff <= nxt_skid_valid;
      ready_ff <= !nxt_skid_valid;
      if (out_free)
      begin
        if (skid_valid_ff)
        begin
          out_ff <= skid_ff;
          out_valid_ff <= 1'b1;
        end
        else
        begin
          out_valid_ff <= keep;
          if (keep)
            out_ff <= in_beat;
        end
      end
      else if (keep)
        skid_ff <= in_beat;
    end
  end

  // ---------------- ancillary parser ----------------
  afe_pkg::afe_parse_e state_ff;
  afe_pkg::afe_parse_e nxt_state;
  logic anc_word;
  logic [7:0] w8;
  logic is_format_ff;
  logic [7:0] udw_left_ff;
  logic [7:0] udw_idx_ff;
  afe_pkg::afe_format_s shadow_ff;
  afe_pkg::afe_format_s fmt_ff;
  logic commit;
  logic changed;
  logic seen_ff;
  logic present_ff;

  assign anc_word = accept && !DIN_SOP && is_anc;
  assign w8 = DIN_DATA[7:0];

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      afe_pkg::ADF0:
        nxt_state = (w8 == `AFE_ADF_FIRST) ? afe_pkg::ADF1 : afe_pkg::ADF0;
      afe_pkg::ADF1:
        nxt_state = (w8 == `AFE_ADF_NEXT) ? afe_pkg::ADF2 : afe_pkg::ADF0;
      afe_pkg::ADF2:
        nxt_state = (w8 == `AFE_ADF_NEXT) ? afe_pkg::DID : afe_pkg::ADF0;
      afe_pkg::DID:
        nxt_state = afe_pkg::SDID;
      afe_pkg::SDID:
        nxt_state = afe_pkg::COUNT;
      afe_pkg::COUNT:
        nxt_state = (w8 == 8'h00) ? afe_pkg::CSUM : afe_pkg::UDW;
      afe_pkg::UDW:
        nxt_state = (udw_left_ff == 8'h01) ? afe_pkg::CSUM : afe_pkg::UDW;
      afe_pkg::CSUM:
        nxt_state = afe_pkg::ADF0;
      default:
        nxt_state = afe_pkg::ADF0;
    endcase
  end

  // every ancillary packet inside the stream is parsed
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      state_ff <= afe_pkg::ADF0;
    else if (accept && DIN_SOP)
      state_ff <= afe_pkg::ADF0;
    else if (anc_word)
      state_ff <= nxt_state;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      is_format_ff <= 1'b0;
      udw_left_ff <= 8'h00;
      udw_idx_ff <= 8'h00;
    end
    else if (anc_word)
    begin
      case (state_ff)
        afe_pkg::DID:
          is_format_ff <= (w8 == `AFE_DID_FORMAT);
        afe_pkg::SDID:
          is_format_ff <= is_format_ff && (w8 == `AFE_SDID_FORMAT);
        afe_pkg::COUNT:
        begin
          udw_left_ff <= w8;
          udw_idx_ff <= 8'h00;
        end
        afe_pkg::UDW:
        begin
          udw_left_ff <= udw_left_ff - 8'h01;
          udw_idx_ff <= udw_idx_ff + 8'h01;
        end
        default:
          udw_idx_ff <= udw_idx_ff;
      endcase
    end
  end

  // user words gathered into a shadow copy until the checksum word
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      shadow_ff <= '0;
    else if (anc_word && state_ff == afe_pkg::UDW && is_format_ff)
    begin
      case (udw_idx_ff)
        `AFE_UDW_CODE:
        begin
          shadow_ff.code <= w8[6:3];
          shadow_ff.aspect <= w8[2];
        end
        `AFE_UDW_FLAGS:
          shadow_ff.flags <= w8[7:4];
        // bar meaning (pixels for 0011, lines for 1100) set by sender
        `AFE_UDW_BAR1_HI:
          shadow_ff.bar_first[15:8] <= w8;
        `AFE_UDW_BAR1_LO:
          shadow_ff.bar_first[7:0] <= w8;
        `AFE_UDW_BAR2_HI:
          shadow_ff.bar_second[15:8] <= w8;
        `AFE_UDW_BAR2_LO:
          shadow_ff.bar_second[7:0] <= w8;
        default:
          shadow_ff <= shadow_ff;
      endcase
    end
  end

  assign commit = anc_word && state_ff == afe_pkg::CSUM && is_format_ff;
  assign changed = commit && (shadow_ff != fmt_ff);

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      fmt_ff <= '0;
    else if (commit)
      fmt_ff <= shadow_ff;
  end

  // presence judged over each image packet interval
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      seen_ff <= 1'b0;
      present_ff <= 1'b0;
    end
    else if (accept && DIN_SOP && DIN_DATA[3:0] == `AFE_TYPE_VIDEO)
    begin
      present_ff <= seen_ff || commit;
      seen_ff <= 1'b0;
    end
    else if (commit)
      seen_ff <= 1'b1;
  end

  // ---------------- register slave ----------------
  logic aw_got_ff;
  logic w_got_ff;
  logic [5:0] aw_idx_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write;
  logic [1:0] irq_flag_ff;
  logic [1:0] nxt_irq_flag;
  logic [1:0] mask_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic irq_ff;
  logic nxt_aw_got;
  logic nxt_w_got;
  logic nxt_bvalid;

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx <= `AFE_IDX_IRQ_MASK);
  endfunction

  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_bvalid = bvalid_ff;
    if (S_AXI_AWVALID && awready_ff)
      nxt_aw_got = 1'b1;
    if (S_AXI_WVALID && wready_ff)
      nxt_w_got = 1'b1;
    if (do_write)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
    end
    else if (bvalid_ff && S_AXI_BREADY)
      nxt_bvalid = 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bresp_ff <= `AFE_RESP_OKAY;
      aw_idx_ff <= 6'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      if (S_AXI_AWVALID && awready_ff)
        aw_idx_ff <= S_AXI_AWADDR[7:2];
      if (S_AXI_WVALID && wready_ff)
      begin
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_write)
        bresp_ff <= mapped(aw_idx_ff) ? `AFE_RESP_OKAY : `AFE_RESP_SLVERR;
    end
  end

  // reserved word and read-only words take no write
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      pass_ff <= `AFE_CTRL_RESET;
      mask_ff <= `AFE_MASK_RESET;
    end
    else if (do_write && wstrb_ff[0])
    begin
      if (aw_idx_ff == `AFE_IDX_CONTROL)
        pass_ff <= wdata_ff[`AFE_CTRL_PASS_BIT];
      if (aw_idx_ff == `AFE_IDX_IRQ_MASK)
        mask_ff <= wdata_ff[1:0];
    end
  end

  // set wins over a clear in the same cycle
  always_comb
  begin
    nxt_irq_flag = irq_flag_ff;
    if (do_write && wstrb_ff[0] && aw_idx_ff == `AFE_IDX_IRQ_FLAG)
      nxt_irq_flag = irq_flag_ff & ~wdata_ff[1:0];
    if (changed)
      nxt_irq_flag[`AFE_IRQ_CHANGE_BIT] = 1'b1;
    nxt_irq_flag[0] = 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      irq_flag_ff <= 2'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_flag_ff <= nxt_irq_flag;
      irq_ff <= |(nxt_irq_flag & mask_ff);
    end
  end

  function automatic logic [31:0] read_mux(input logic [5:0] idx);
    read_mux = 32'h00000000;
    case (idx)
      `AFE_IDX_CONTROL:
        read_mux[0] = pass_ff;
      `AFE_IDX_RESERVED:
        read_mux = 32'h00000000;
      `AFE_IDX_IRQ_FLAG:
        read_mux[1:0] = irq_flag_ff;
      `AFE_IDX_FORMAT:
        read_mux[3:0] = fmt_ff.code;
      `AFE_IDX_ASPECT:
        read_mux[0] = fmt_ff.aspect;
      `AFE_IDX_BAR_FLAGS:
        read_mux[3:0] = fmt_ff.flags;
      `AFE_IDX_BAR_FIRST:
        read_mux[15:0] = fmt_ff.bar_first;
      `AFE_IDX_BAR_SECOND:
        read_mux[15:0] = fmt_ff.bar_second;
      `AFE_IDX_PRESENT:
        read_mux[0] = present_ff;
      `AFE_IDX_IRQ_MASK:
        read_mux[1:0] = mask_ff;
      default:
        read_mux = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `AFE_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= read_mux(S_AXI_ARADDR[7:2]);
      rresp_ff <= mapped(S_AXI_ARADDR[7:2]) ? `AFE_RESP_OKAY
                                             : `AFE_RESP_SLVERR;
    end
    else if (rvalid_ff)
    begin
      if (S_AXI_RREADY)
        rvalid_ff <= 1'b0;
      arready_ff <= S_AXI_RREADY;
    end
    else
      arready_ff <= 1'b1;
  end

  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign DIN_READY = ready_ff;
  assign DOUT_DATA = out_ff.data;
  assign DOUT_SOP = out_ff.sop;
  assign DOUT_EOP = out_ff.eop;
  assign DOUT_VALID = out_valid_ff;
  assign IRQ = irq_ff;

endmodule

// file: afe_params.svh
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH

// register indices; byte address is four times the index
`define AFE_IDX_CONTROL 6'h00
`define AFE_IDX_RESERVED 6'h01
`define AFE_IDX_IRQ_FLAG 6'h02
`define AFE_IDX_FORMAT 6'h03
`define AFE_IDX_ASPECT 6'h04
`define AFE_IDX_BAR_FLAGS 6'h05
`define AFE_IDX_BAR_FIRST 6'h06
`define AFE_IDX_BAR_SECOND 6'h07
`define AFE_IDX_PRESENT 6'h08
`define AFE_IDX_IRQ_MASK 6'h09

`define AFE_CTRL_PASS_BIT 0
`define AFE_IRQ_CHANGE_BIT 1

`define AFE_CTRL_RESET 1'h0
`define AFE_MASK_RESET 2'h0

// packet type codes in the header beat
`define AFE_TYPE_VIDEO 4'h0
`define AFE_TYPE_ANC 4'hD

// ancillary data flag words and identifiers
`define AFE_ADF_FIRST 8'h00
`define AFE_ADF_NEXT 8'hFF
`define AFE_DID_FORMAT 8'h41
`define AFE_SDID_FORMAT 8'h05

// user data word positions within the format packet
`define AFE_UDW_CODE 8'h00
`define AFE_UDW_FLAGS 8'h03
`define AFE_UDW_BAR1_HI 8'h04
`define AFE_UDW_BAR1_LO 8'h05
`define AFE_UDW_BAR2_HI 8'h06
`define AFE_UDW_BAR2_LO 8'h07

`define AFE_RESP_OKAY 2'h0
`define AFE_RESP_SLVERR 2'h2

`endif

// file: afe_pkg.sv
package afe_pkg;

  typedef logic [9:0] afe_word_t;

  typedef struct packed {
    afe_word_t data;
    logic sop;
    logic eop;
  } afe_beat_s;

  typedef struct packed {
    logic [3:0] code;
    logic aspect;
    logic [3:0] flags;
    logic [15:0] bar_first;
    logic [15:0] bar_second;
  } afe_format_s;

  typedef enum logic [2:0] {
    ADF0,
    ADF1,
    ADF2,
    DID,
    SDID,
    COUNT,
    UDW,
    CSUM
  } afe_parse_e;

endpackage

// file: afe_sva.sv
`timescale 1ns/1ps
`include "afe_params.svh"
module afe_sva (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic [9:0] DIN_DATA,
  input wire logic DIN_SOP,
  input wire logic DIN_VALID,
  input wire logic DIN_READY,
  input wire logic [9:0] DOUT_DATA,
  input wire logic DOUT_SOP,
  input wire logic DOUT_VALID,
  input wire logic DOUT_READY
);
  logic ctl_ff;
  logic ctl_dly_ff;
  logic [5:0] ari;
  assign ari = S_AXI_ARADDR[7:2];
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // shadow of the pass bit, delayed to line up with the register
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      ctl_ff <= 1'h0;
      ctl_dly_ff <= 1'h0;
    end
    else
    begin
      ctl_dly_ff <= ctl_ff;
      if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
          S_AXI_WREADY && S_AXI_AWADDR[7:2] == `AFE_IDX_CONTROL)
        ctl_ff <= S_AXI_WDATA[0];
    end
  end
  sequence s_ar;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_vid;
    DIN_VALID && DIN_READY && DIN_SOP && DIN_DATA[3:0] == 4'h0;
  endsequence
  property p_r_lat;
    s_ar |-> ##[1:2] S_AXI_RVALID;
  endproperty
  property p_no_anc;
    !(DOUT_VALID && DOUT_SOP && DOUT_DATA[3:0] == 4'hD);
  endproperty
  property p_fwd;
    s_vid ##0 (ctl_dly_ff && !DOUT_VALID) |=>
      DOUT_VALID && DOUT_SOP && DOUT_DATA == $past(DIN_DATA);
  endproperty
  property p_drop_all;
    (!ctl_dly_ff) [*8] |-> !DOUT_VALID;
  endproperty
  property p_rsvd;
    s_ar ##0 (ari == 6'h01) |-> ##[1:2] (S_AXI_RVALID && S_AXI_RDATA == 0);
  endproperty
  property p_nib;
    s_ar ##0 (ari == 6'h03 || ari == 6'h05) |->
      ##[1:2] (S_AXI_RVALID && S_AXI_RDATA[31:4] == 0);
  endproperty
  property p_bit;
    s_ar ##0 (ari == 6'h04 || ari == 6'h08) |->
      ##[1:2] (S_AXI_RVALID && S_AXI_RDATA[31:1] == 0);
  endproperty
  property p_half;
    s_ar ##0 (ari == 6'h06 || ari == 6'h07) |->
      ##[1:2] (S_AXI_RVALID && S_AXI_RDATA[31:16] == 0);
  endproperty
  property p_dout_hold;
    DOUT_VALID && !DOUT_READY |=> DOUT_VALID && $stable(DOUT_DATA);
  endproperty
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  a_no_anc: assert property (p_no_anc)
    else $error("ancillary packet forwarded");
  a_fwd: assert property (p_fwd)
    else $error("video packet not forwarded");
  a_drop_all: assert property (p_drop_all)
    else $error("output while pass bit clear");
  a_rsvd: assert property (p_rsvd)
    else $error("reserved word not zero");
  a_nib: assert property (p_nib)
    else $error("nibble register upper bits set");
  a_bit: assert property (p_bit)
    else $error("bit register upper bits set");
  a_half: assert property (p_half)
    else $error("bar value upper bits set");
  a_dout_hold: assert property (p_dout_hold)
    else $error("output beat changed while stalled");
endmodule

bind afe_extractor afe_sva u_sva (
  .MCLK(MCLK),
  .SYS_RST(SYS_RST),
  .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID),
  .DIN_DATA(DIN_DATA),
  .DIN_SOP(DIN_SOP),
  .DIN_VALID(DIN_VALID),
  .DIN_READY(DIN_READY),
  .DOUT_DATA(DOUT_DATA),
  .DOUT_SOP(DOUT_SOP),
  .DOUT_VALID(DOUT_VALID),
  .DOUT_READY(DOUT_READY)
);

// file: afe_src.sv
`timescale 1ns/1ps
module afe_src (
  input wire logic mclk,
  output logic [9:0] din_data,
  output logic din_sop,
  output logic din_eop,
  output logic din_valid,
  input wire logic din_ready
);
  int stuck_count;
  initial
  begin
    din_data = 10'h000;
    din_sop = 1'h0;
    din_eop = 1'h0;
    din_valid = 1'h0;
    stuck_count = 0;
  end
  task automatic put(input logic [9:0] d, input logic s, input logic e);
    int n;
    din_data <= d;
    din_sop <= s;
    din_eop <= e;
    din_valid <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (!din_ready && n < 100);
    if (n >= 100)
      stuck_count++;
  endtask
  task automatic idle;
    din_valid <= 1'h0;
    din_sop <= 1'h0;
    din_eop <= 1'h0;
    // one idle edge so the next packet never re-raises valid in this step
    @(posedge mclk);
  endtask
endmodule

// file: afe_tb.sv
`timescale 1ns/1ps
`include "afe_params.svh"
module testbench;
  logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [9:0] din_data, dout_data;
  logic din_sop, din_eop, din_valid, din_ready;
  logic dout_sop, dout_eop, dout_valid, dout_ready;
  logic [11:0] exp_q[$], got_q[$];
  int bad_count, samples_checked, i;
  afe_extractor dut (
    .MCLK(mclk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .DIN_DATA(din_data), .DIN_SOP(din_sop), .DIN_EOP(din_eop),
    .DIN_VALID(din_valid), .DIN_READY(din_ready),
    .DOUT_DATA(dout_data), .DOUT_SOP(dout_sop), .DOUT_EOP(dout_eop),
    .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready), .IRQ(irq)
  );
  afe_src src (.mclk(mclk), .din_data(din_data), .din_sop(din_sop),
    .din_eop(din_eop), .din_valid(din_valid), .din_ready(din_ready));
  always #4 mclk = ~mclk;
  always @(posedge mclk)
    if (dout_valid && dout_ready)
      got_q.push_back({dout_sop, dout_eop, dout_data});
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic ck(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60)
    begin
      bad_count++;
      end_of_test();
    end
  endtask
  task automatic axw(input logic [5:0] a, input logic [31:0] v,
                     input logic [1:0] er);
    int n;
    awaddr <= {a, 2'h0};
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end while (!bvalid && n < 60);
    tmo(n);
    ck("bresp", bresp, er);
  endtask
  task automatic axr(input logic [5:0] a, output logic [31:0] v,
                     output logic [1:0] rr);
    int n;
    araddr <= {a, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
      if (arready)
        arvalid <= 1'h0;
    end while (!rvalid && n < 60);
    v = rdata;
    rr = rresp;
    tmo(n);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rr;
    axr(a, v, rr);
    ck($sformatf("reg%0d", a), v, e);
    ck("rresp", rr, `AFE_RESP_OKAY);
  endtask
  task automatic ci(input logic e);
    repeat (2) @(posedge mclk);
    ck("irq", irq, e);
  endtask
  task automatic sb(input logic [9:0] v, input logic s, e, f);
    src.put(v, s, e);
    if (f)
      exp_q.push_back({s, e, v});
  endtask
  task automatic vid(input int n, input logic [9:0] b, input logic f);
    int k;
    sb({6'h00, `AFE_TYPE_VIDEO}, 1'h1, 1'h0, f);
    for (k = 0; k < n; k++)
      sb(b + k[9:0], 1'h0, k == n - 1, f);
    src.idle();
  endtask
  // ancillary packet with eight user words, byte 7 (top byte of u) sent first
  task automatic anc(input logic [7:0] sd, input logic [63:0] u);
    logic [8:0] cs;
    int k;
    src.put({6'h00, `AFE_TYPE_ANC}, 1'h1, 1'h0);
    src.put(10'h000, 1'h0, 1'h0);
    src.put(10'h0FF, 1'h0, 1'h0);
    src.put(10'h0FF, 1'h0, 1'h0);
    src.put(10'h041, 1'h0, 1'h0);
    src.put({2'h0, sd}, 1'h0, 1'h0);
    src.put(10'h008, 1'h0, 1'h0);
    cs = 9'h049 + {1'h0, sd};
    for (k = 7; k >= 0; k--)
    begin
      src.put({2'h0, u[k*8+:8]}, 1'h0, 1'h0);
      cs = cs + {1'h0, u[k*8+:8]};
    end
    src.put({~cs[8], cs}, 1'h0, 1'h1);
    src.idle();
  endtask
  function automatic logic [63:0] fw(input logic [3:0] c, input logic a,
    input logic [3:0] f, input logic [15:0] b1, b2);
    return {1'h0, c, a, 2'h0, 16'h0000, f, 4'h0, b1, b2};
  endfunction
  task automatic drain;
    int n;
    repeat (4) @(posedge mclk);
    n = 0;
    while (got_q.size() != exp_q.size() && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    ck("beats", got_q.size(), exp_q.size());
    foreach (exp_q[k])
      ck("beat", got_q[k], exp_q[k]);
    exp_q.delete();
    got_q.delete();
  endtask
  initial
  begin
    mclk = 1'h0; sys_rst = 1'h1; awaddr = 8'h00; araddr = 8'h00;
    awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0;
    rready = 1'h0; wdata = 32'h0; wstrb = 4'hF; dout_ready = 1'h1;
    bad_count = 0; samples_checked = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'h0;
    @(posedge mclk);
    for (i = 0; i < 10; i++)
      rc(i[5:0], 32'h0);
    axr(6'h0A, d, r);
    ck("rresp", r, `AFE_RESP_SLVERR);
    vid(3, 10'h010, 1'h0);
    drain();
    axw(`AFE_IDX_CONTROL, 32'h1, `AFE_RESP_OKAY);
    axw(`AFE_IDX_IRQ_MASK, 32'h2, `AFE_RESP_OKAY);
    vid(3, 10'h020, 1'h1);
    anc(`AFE_SDID_FORMAT, fw(4'h3, 1'h1, 4'hA, 16'h1234, 16'h5678));
    vid(2, 10'h030, 1'h1);
    drain();
    ci(1'h1);
    rc(2, 32'h2);
    rc(3, 32'h3);
    rc(4, 32'h1);
    rc(5, 32'hA);
    rc(6, 32'h1234);
    rc(7, 32'h5678);
    rc(8, 32'h1);
    vid(1, 10'h040, 1'h1);
    rc(8, 32'h0);
    axw(`AFE_IDX_IRQ_FLAG, 32'h2, `AFE_RESP_OKAY);
    rc(2, 32'h0);
    ci(1'h0);
    anc(`AFE_SDID_FORMAT, fw(4'h3, 1'h1, 4'hA, 16'h1234, 16'h5678));
    rc(2, 32'h0);
    anc(8'h06, fw(4'h8, 1'h0, 4'h1, 16'h0001, 16'h0002));
    rc(3, 32'h3);
    anc(`AFE_SDID_FORMAT, fw(4'hC, 1'h0, 4'h5, 16'h0010, 16'h0400));
    rc(2, 32'h2);
    rc(3, 32'hC);
    rc(6, 32'h0010);
    rc(7, 32'h0400);
    axw(`AFE_IDX_IRQ_MASK, 32'h0, `AFE_RESP_OKAY);
    ci(1'h0);
    axw(`AFE_IDX_IRQ_MASK, 32'h2, `AFE_RESP_OKAY);
    ci(1'h1);
    axw(`AFE_IDX_IRQ_FLAG, 32'h2, `AFE_RESP_OKAY);
    ci(1'h0);
    axw(`AFE_IDX_RESERVED, 32'hFFFFFFFF, `AFE_RESP_OKAY);
    rc(1, 32'h0);
    rc(0, 32'h1);
    axw(6'h0C, 32'h5, `AFE_RESP_SLVERR);
    dout_ready <= 1'h0;
    fork
      vid(6, 10'h050, 1'h1);
      begin
        repeat (12) @(posedge mclk);
        ck("din_ready", din_ready, 1'h0);
        dout_ready <= 1'h1;
      end
    join
    drain();
    ck("stuck", src.stuck_count, 0);
    end_of_test();
  end
endmodule
